// ### ocp_pkg_tapdiv.sv
/*
 * Shared constants and types for the octal serial capture clocking block, and
 * the tap-mode serial clock divider with launch/capture tap pulses.
 * Assumes one reference clock, aclk, with a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
package ocp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PHYCFG_OFS = 8'h04;
  localparam logic [7:0] TAP_OFS    = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0c;
  // field positions
  localparam int CTRL_EN_POS   = 0;
  localparam int CTRL_MODE_POS = 1;
  localparam int CTRL_TOPO_POS = 2;
  localparam int CTRL_DDR_POS  = 4;
  localparam int PHY_TX_POS    = 0;
  localparam int PHY_RX_POS    = 16;
  localparam int TAP_TX_POS    = 0;
  localparam int TAP_RX_POS    = 8;
  localparam int DLY_W         = 7;
  localparam int TAPSEL_W      = 3;
  // reset values
  localparam logic [DLY_W-1:0]    DLY_RST = 7'h00;
  localparam logic [TAPSEL_W-1:0] TAP_RST = 3'h0;
  // reference and serial clock rates
  localparam int REF_MAX_MHZ  = 200;
  localparam int SDR_DIV      = 4;
  localparam int DDR_DIV      = 8;
  localparam int SDR_MAX_MHZ  = REF_MAX_MHZ / SDR_DIV;
  localparam int DDR_MAX_MHZ  = REF_MAX_MHZ / DDR_DIV;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {MODE_PHY = 1'b0, MODE_TAP = 1'b1} ocp_mode_t;
  typedef enum logic [1:0] {
    TOPO_NONE     = 2'b00,
    TOPO_INT_PHY  = 2'b01,
    TOPO_INT_PAD  = 2'b10,
    TOPO_STROBE   = 2'b11
  } ocp_topo_t;
  typedef enum logic [1:0] {
    CAP_REF      = 2'b00,
    CAP_LOOPBACK = 2'b01,
    CAP_STROBE   = 2'b10
  } ocp_cap_t;
  typedef struct packed {
    logic      ddr;
    ocp_topo_t topo;
    ocp_mode_t mode;
    logic      en;
  } ocp_ctrl_t;
  localparam ocp_ctrl_t CTRL_RST = '{ddr: 1'b0, topo: TOPO_INT_PHY, mode: MODE_PHY, en: 1'b0};
endpackage
`default_nettype wire

`default_nettype none
module ocp_tapdiv (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // configuration
  input  wire logic                         run_i,
  input  wire logic                         ddr_i,
  input  wire logic [ocp_pkg::TAPSEL_W-1:0] tx_tap_i,
  input  wire logic [ocp_pkg::TAPSEL_W-1:0] rx_tap_i,
  // divided clock and tap pulses
  output logic                              sclk_q,
  output logic                              launch_q,
  output logic                              capture_q
);
  logic [2:0] ph_q;
  logic [2:0] last;
  logic [2:0] half;
  logic       ddr_q;

  assign last = ddr_i ? 3'(ocp_pkg::DDR_DIV - 1) : 3'(ocp_pkg::SDR_DIV - 1);
  assign half = ddr_i ? 3'(ocp_pkg::DDR_DIV / 2) : 3'(ocp_pkg::SDR_DIV / 2);

  // phase restarts on a rate change, and the clock pulse in progress can be cut short
  always_ff @(posedge aclk) begin
    ddr_q <= ddr_i;
    if (!aresetn || !run_i || ddr_q != ddr_i) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= (ph_q == last) ? 3'h0 : ph_q + 3'h1; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q    <= 1'b0;
      launch_q  <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      sclk_q    <= run_i && ph_q >= half; // R8
      launch_q  <= run_i && ph_q == (tx_tap_i & last); // R9
      capture_q <= run_i && ph_q == (rx_tap_i & last); // R9
    end
  end

  a_sdr_div_four: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    $rose(sclk_q) && !ddr_i |-> (sclk_q[*2] ##1 !sclk_q[*2]) or (##[0:3] (!run_i || ddr_i)))
    else $error("sdr tap clock is not ref divided by 4");
  a_ddr_div_eight: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    $rose(sclk_q) && ddr_i |-> (sclk_q[*4] ##1 !sclk_q[*4]) or (##[0:7] (!run_i || !ddr_i)))
    else $error("ddr tap clock is not ref divided by 8");
endmodule
`default_nettype wire

// ### ocp_capture_clocking.sv
/*
 * Capture clock control for an octal serial flash interface: mode and topology
 * selection, serial clock generation, delay-line settings, AXI4-Lite registers.
 * Assumes aclk is the internal reference clock and the PHY muxes clocks itself.
 */
// What this block does
// R1: two receive capture modes exist, delay-line PHY mode and tap mode, chosen by configuration.
// R2: PHY mode makes one full serial clock per reference cycle at SDR and half of one at DDR.
// R3: the internal PHY loopback topology captures with the reference clock.
// R4: the internal pad loopback topology captures with the loopback clock returned through the strobe pin.
// R5: the strobe topology captures with the strobe that the memory drives.
// R6: SDR is refused with pad loopback or strobe topology.
// R7: DDR is refused with pad loopback topology.
// R8: tap mode divides the reference clock by 4 for SDR and by 8 for DDR.
// R9: tap mode offers selectable taps moving transmit launch and receive capture.
// R10: tap mode supports only no-loopback, capturing with the reference clock.
// R11: in tap mode the reference clock may not exceed 200MHz, giving 50MHz SDR and 25MHz DDR at most.
// R12: separate transmit and receive delay-line settings are held and applied in all modes.
// R13: any unsupported mode, topology and rate combination is flagged and not run.
`timescale 1ns/1ps
`default_nettype none
module ocp_capture_clocking #(
  parameter int REF_CLK_MHZ = 200
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // memory side pins
  input  wire logic        strobe_pin,
  output logic             serial_clk_out,
  output logic             loopback_clk_out,
  // phy controls
  output logic             phy_en,
  output logic             phy_half_cycle,
  output logic [1:0]       capture_sel,
  output logic [6:0]       tx_delay_line_setting,
  output logic [6:0]       rx_delay_line_setting,
  output logic             tap_launch,
  output logic             tap_capture,
  output logic             cfg_error
);
  ////////////////////////////////////////////////////////////////////////////
  ocp_pkg::ocp_ctrl_t               ctrl_q;
  logic [ocp_pkg::DLY_W-1:0]        tx_dly_q, rx_dly_q;
  logic [ocp_pkg::TAPSEL_W-1:0]     tx_tap_q, rx_tap_q;
  logic                             aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic                             arready_q, rvalid_q;
  logic [1:0]                       bresp_q, rresp_q;
  logic [31:0]                      rdata_q, wdata_q;
  logic [3:0]                       wstrb_q;
  logic [7:0]                       awaddr_q;
  logic                             aw_fire, w_fire, ar_fire, wr_go;
  logic                             aw_have_d, w_have_d, bvalid_d, rvalid_d;
  logic [31:0]                      rd_val, wr_img;
  logic                             rd_hit;
  logic [2:0]                       strb_sync_q;
  logic                             strobe_lvl_q;
  logic                             combo_bad, rate_ok, run_phy, run_tap;
  logic                             phy_en_q, phy_half_q, lb_q, err_q;
  ocp_pkg::ocp_cap_t                cap_q;
  logic                             tap_sclk, tap_launch_w, tap_capture_w;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_image(input logic [7:0] a, input ocp_pkg::ocp_ctrl_t c,
                                            input logic [6:0] tx, input logic [6:0] rx,
                                            input logic [2:0] tt, input logic [2:0] rt,
                                            input logic [7:0] st);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      ocp_pkg::CTRL_OFS:   r[4:0] = c;
      ocp_pkg::PHYCFG_OFS: begin
        r[ocp_pkg::PHY_TX_POS +: ocp_pkg::DLY_W] = tx;
        r[ocp_pkg::PHY_RX_POS +: ocp_pkg::DLY_W] = rx;
      end
      ocp_pkg::TAP_OFS: begin
        r[ocp_pkg::TAP_TX_POS +: ocp_pkg::TAPSEL_W] = tt;
        r[ocp_pkg::TAP_RX_POS +: ocp_pkg::TAPSEL_W] = rt;
      end
      ocp_pkg::STAT_OFS:   r[7:0] = st;
      default:             r = 32'h0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight, address and data in any order
  assign aw_fire   = awvalid && awready_q;
  assign w_fire    = wvalid && wready_q;
  assign ar_fire   = arvalid && arready_q;
  assign wr_go     = aw_have_q && w_have_q;
  assign aw_have_d = !wr_go && (aw_have_q || aw_fire);
  assign w_have_d  = !wr_go && (w_have_q || w_fire);
  assign bvalid_d  = wr_go || (bvalid_q && !bready);
  assign rvalid_d  = ar_fire || (rvalid_q && !rready);
  assign rd_hit    = araddr == ocp_pkg::CTRL_OFS || araddr == ocp_pkg::PHYCFG_OFS ||
                     araddr == ocp_pkg::TAP_OFS || araddr == ocp_pkg::STAT_OFS;
  assign rd_val    = reg_image(araddr, ctrl_q, tx_dly_q, rx_dly_q, tx_tap_q, rx_tap_q,
                               {2'h0, rate_ok, strobe_lvl_q, 2'(cap_q), run_phy || run_tap, err_q});
  assign wr_img    = merge(reg_image(awaddr_q, ctrl_q, tx_dly_q, rx_dly_q, tx_tap_q, rx_tap_q, 8'h0),
                           wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ocp_pkg::RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q  <= !w_have_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_fire) begin
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        bresp_q <= (awaddr_q == ocp_pkg::CTRL_OFS || awaddr_q == ocp_pkg::PHYCFG_OFS ||
                    awaddr_q == ocp_pkg::TAP_OFS) ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= ocp_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= rd_val;
        rresp_q <= rd_hit ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ocp_pkg::CTRL_RST;
    end else if (wr_go && awaddr_q == ocp_pkg::CTRL_OFS) begin
      ctrl_q <= ocp_pkg::ocp_ctrl_t'(wr_img[4:0]); // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_dly_q <= ocp_pkg::DLY_RST;
      rx_dly_q <= ocp_pkg::DLY_RST;
    end else if (wr_go && awaddr_q == ocp_pkg::PHYCFG_OFS) begin
      tx_dly_q <= wr_img[ocp_pkg::PHY_TX_POS +: ocp_pkg::DLY_W]; // R12
      rx_dly_q <= wr_img[ocp_pkg::PHY_RX_POS +: ocp_pkg::DLY_W]; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_tap_q <= ocp_pkg::TAP_RST;
      rx_tap_q <= ocp_pkg::TAP_RST;
    end else if (wr_go && awaddr_q == ocp_pkg::TAP_OFS) begin
      tx_tap_q <= wr_img[ocp_pkg::TAP_TX_POS +: ocp_pkg::TAPSEL_W]; // R9
      rx_tap_q <= wr_img[ocp_pkg::TAP_RX_POS +: ocp_pkg::TAPSEL_W]; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // legality of mode, topology and rate
  assign rate_ok = REF_CLK_MHZ <= ocp_pkg::REF_MAX_MHZ; // R11
  always_comb begin
    combo_bad = 1'b0;
    unique case (ctrl_q.mode)
      ocp_pkg::MODE_TAP: combo_bad = ctrl_q.topo != ocp_pkg::TOPO_NONE || !rate_ok; // R10 R11
      ocp_pkg::MODE_PHY: begin
        unique case (ctrl_q.topo)
          ocp_pkg::TOPO_NONE:    combo_bad = 1'b1;
          ocp_pkg::TOPO_INT_PHY: combo_bad = 1'b0;
          ocp_pkg::TOPO_INT_PAD: combo_bad = 1'b1; // R6 R7
          ocp_pkg::TOPO_STROBE:  combo_bad = !ctrl_q.ddr; // R6
        endcase
      end
    endcase
  end
  // an illegal setup is reported and kept stopped rather than run half right
  assign run_phy = ctrl_q.en && !combo_bad && ctrl_q.mode == ocp_pkg::MODE_PHY; // R13
  assign run_tap = ctrl_q.en && !combo_bad && ctrl_q.mode == ocp_pkg::MODE_TAP; // R13

  ////////////////////////////////////////////////////////////////////////////
  // capture clock source and phy clocking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q      <= ocp_pkg::CAP_REF;
      phy_en_q   <= 1'b0;
      phy_half_q <= 1'b0;
      lb_q       <= 1'b0;
      err_q      <= 1'b0;
    end else begin
      unique case (ctrl_q.topo)
        ocp_pkg::TOPO_INT_PAD: cap_q <= ocp_pkg::CAP_LOOPBACK; // R4
        ocp_pkg::TOPO_STROBE:  cap_q <= ocp_pkg::CAP_STROBE; // R5
        default:               cap_q <= ocp_pkg::CAP_REF; // R3 R10
      endcase
      phy_en_q   <= run_phy; // R1
      phy_half_q <= ctrl_q.ddr; // R2
      lb_q       <= run_phy && ctrl_q.topo == ocp_pkg::TOPO_INT_PAD; // R4
      err_q      <= ctrl_q.en && combo_bad; // R13
    end
  end

  // strobe pin is asynchronous: three stages, level accepted when the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strb_sync_q  <= 3'h0;
      strobe_lvl_q <= 1'b0;
    end else begin
      strb_sync_q <= {strb_sync_q[1:0], strobe_pin};
      if (strb_sync_q[1] == strb_sync_q[2]) begin
        strobe_lvl_q <= strb_sync_q[2];
      end
    end
  end

  ocp_tapdiv u_tapdiv (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run_i     (run_tap),
    .ddr_i     (ctrl_q.ddr),
    .tx_tap_i  (tx_tap_q),
    .rx_tap_i  (rx_tap_q),
    .sclk_q    (tap_sclk),
    .launch_q  (tap_launch_w),
    .capture_q (tap_capture_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign awready               = awready_q;
  assign wready                = wready_q;
  assign bvalid                = bvalid_q;
  assign bresp                 = bresp_q;
  assign arready               = arready_q;
  assign rvalid                = rvalid_q;
  assign rdata                 = rdata_q;
  assign rresp                 = rresp_q;
  assign serial_clk_out        = tap_sclk;
  assign loopback_clk_out      = lb_q;
  assign phy_en                = phy_en_q;
  assign phy_half_cycle        = phy_half_q;
  assign capture_sel           = cap_q;
  assign tx_delay_line_setting = tx_dly_q;
  assign rx_delay_line_setting = rx_dly_q;
  assign tap_launch            = tap_launch_w;
  assign tap_capture           = tap_capture_w;
  assign cfg_error             = err_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_written(logic [7:0] ofs);
    wr_go && awaddr_q == ofs;
  endsequence

  a_mode_exclusive: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    !(phy_en && serial_clk_out) && !(phy_en && $past(ctrl_q.mode) == ocp_pkg::MODE_TAP))
    else $error("phy and tap mode active together");
  a_phy_rate_ratio: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    run_phy |=> phy_en && phy_half_cycle == $past(ctrl_q.ddr))
    else $error("phy cycle ratio does not follow rate");
  a_int_phy_ref: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    ctrl_q.topo == ocp_pkg::TOPO_INT_PHY |=> capture_sel == ocp_pkg::CAP_REF)
    else $error("internal phy loopback not on reference clock");
  a_pad_loopback: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    ctrl_q.topo == ocp_pkg::TOPO_INT_PAD |=> capture_sel == ocp_pkg::CAP_LOOPBACK)
    else $error("pad loopback not on loopback clock");
  a_strobe_source: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    ctrl_q.topo == ocp_pkg::TOPO_STROBE |=> capture_sel == ocp_pkg::CAP_STROBE)
    else $error("strobe topology not on strobe");
  a_sdr_refused: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    ctrl_q.en && !ctrl_q.ddr && ctrl_q.mode == ocp_pkg::MODE_PHY &&
    ctrl_q.topo inside {ocp_pkg::TOPO_INT_PAD, ocp_pkg::TOPO_STROBE} |=> cfg_error && !phy_en)
    else $error("sdr ran on pad loopback or strobe");
  a_ddr_pad_refused: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    ctrl_q.en && ctrl_q.ddr && ctrl_q.topo == ocp_pkg::TOPO_INT_PAD |=> cfg_error && !phy_en)
    else $error("ddr ran on pad loopback");
  a_tap_no_loop: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    ctrl_q.en && ctrl_q.mode == ocp_pkg::MODE_TAP && ctrl_q.topo != ocp_pkg::TOPO_NONE
    |=> cfg_error ##1 !serial_clk_out)
    else $error("tap mode ran with a loopback topology");
  a_delay_applied: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    s_cfg_written(ocp_pkg::PHYCFG_OFS) |=>
    tx_delay_line_setting == $past(wr_img[6:0]) && rx_delay_line_setting == $past(wr_img[22:16]))
    else $error("delay-line setting not applied");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    aw_fire && w_fire |=> ##1 bvalid)
    else $error("write not answered in two cycles");
endmodule
`default_nettype wire

// ### ocp_mem_model.sv
/*
 * Model of the attached octal memory on the strobe pin: drives the data
 * strobe while the bench enables it. Assumes the strobe board net has a pull-down.
 */
`timescale 1ns/1ps
`default_nettype none
module ocp_mem_model (
  // clock
  input  wire logic aclk,
  // bench control
  input  wire logic drive_en,
  input  wire logic toggle,
  // strobe wire
  output logic      strobe
);
  logic lvl_q = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (drive_en && toggle) lvl_q <= ~lvl_q;
  end

  // a released strobe must not show its last level, so the pull-down wins
  assign strobe = drive_en ? lvl_q : 1'h0;
endmodule
`default_nettype wire

// ### ocp_capture_clocking_tb.sv
/*
 * Self-checking bench for the capture clocking block: reset values, every
 * mode/topology/rate pair, tap clock division and phases, delay settings.
 * Assumes the memory model drives the strobe pin and a 200 MHz aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ocp_capture_clocking_tb;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, mem_drive = 1'h0, mem_toggle = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, capture_sel;
  logic [6:0]  tx_delay_line_setting, rx_delay_line_setting;
  logic        awready, wready, bvalid, arready, rvalid, strobe_pin, serial_clk_out;
  logic        loopback_clk_out, phy_en, phy_half_cycle, tap_launch, tap_capture, cfg_error;
  int          num_errors = 0, check_count = 0;

  ocp_capture_clocking #(.REF_CLK_MHZ(200)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .strobe_pin, .serial_clk_out, .loopback_clk_out, .phy_en, .phy_half_cycle,
    .capture_sel, .tx_delay_line_setting, .rx_delay_line_setting, .tap_launch,
    .tap_capture, .cfg_error);
  ocp_mem_model mem (.aclk, .drive_en(mem_drive), .toggle(mem_toggle), .strobe(strobe_pin));

  always #2.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit ok;
    ok = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        r = bresp;
        ok = 1;
      end
    end
    bready <= 1'h0;
    @(posedge aclk);
    if (!ok) begin
      check(0, "write timeout");
      stop_test();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        r = rresp;
        ok = 1;
      end
    end
    rready <= 1'h0;
    @(posedge aclk);
    if (!ok) begin
      check(0, "read timeout");
      stop_test();
    end
  endtask

  // period of the serial clock, and launch/capture offsets from its rising edge
  task automatic measure(output int per, output int lo, output int co, output int nl);
    logic p;
    int   r1, r2;
    p = serial_clk_out;
    r1 = -1;
    r2 = -1;
    lo = -1;
    co = -1;
    nl = 0;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (serial_clk_out === 1'h1 && p === 1'h0) begin
        if (r1 < 0) r1 = n;
        else if (r2 < 0) r2 = n;
      end
      if (r1 >= 0 && r2 < 0 && tap_launch === 1'h1) begin
        nl++;
        lo = n - r1;
      end
      if (r1 >= 0 && r2 < 0 && tap_capture === 1'h1) co = n - r1;
      p = serial_clk_out;
    end
    per = r2 - r1;
  endtask

  function automatic logic exp_err(input ocp_pkg::ocp_ctrl_t c);
    logic ok;
    if (c.mode == ocp_pkg::MODE_PHY)
      ok = c.topo == ocp_pkg::TOPO_INT_PHY || (c.topo == ocp_pkg::TOPO_STROBE && c.ddr);
    else
      ok = c.topo == ocp_pkg::TOPO_NONE;
    return c.en && !ok;
  endfunction

  function automatic logic [1:0] exp_cap(input ocp_pkg::ocp_ctrl_t c);
    case (c.topo)
      ocp_pkg::TOPO_INT_PAD: return 2'h1;
      ocp_pkg::TOPO_STROBE:  return 2'h2;
      default:               return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ocp_pkg::ocp_ctrl_t c;
    logic [31:0] d, e, f;
    logic [1:0]  r;
    int          per, lo, co, nl, lo0, co0, t, u, dv;
    void'($urandom(32'hdcceb946));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    axi_rd(ocp_pkg::CTRL_OFS, d, r);
    check(d === 32'h4 && capture_sel === 2'h0, "ctrl reset");
    axi_rd(ocp_pkg::STAT_OFS, d, r);
    check(d === 32'h20, "status reset");
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      c = ocp_pkg::ocp_ctrl_t'(i[4:0]);
      axi_wr(ocp_pkg::CTRL_OFS, {27'h0, c}, 4'hf, r);
      repeat (3) @(posedge aclk);
      check(cfg_error === exp_err(c), "cfg_error");
      check(phy_en === (c.en && !exp_err(c) && c.mode == ocp_pkg::MODE_PHY), "phy_en");
      check(capture_sel === exp_cap(c), "capture_sel");
      check(loopback_clk_out === 1'h0, "loopback clock");
      if (phy_en === 1'h1) check(phy_half_cycle === c.ddr, "half cycle");
      measure(per, lo, co, nl);
      if (c.en && !exp_err(c) && c.mode == ocp_pkg::MODE_TAP) begin
        check(per == (c.ddr ? 8 : 4) && nl == 1, "tap divide");
      end else check(per == 0, "clock idle");
    end
    $display("test mode table done");
    // taps shift launch and capture by whole reference cycles
    for (int k = 0; k < 2; k++) begin
      dv = k ? 8 : 4;
      axi_wr(ocp_pkg::CTRL_OFS, {27'h0, k[0], 4'h3}, 4'hf, r);
      axi_wr(ocp_pkg::TAP_OFS, 32'h0, 4'hf, r);
      repeat (4) @(posedge aclk);
      measure(per, lo0, co0, nl);
      repeat (3) begin
        t = $urandom_range(dv - 1);
        u = $urandom_range(dv - 1);
        axi_wr(ocp_pkg::TAP_OFS, {21'h0, u[2:0], 5'h0, t[2:0]}, 4'hf, r);
        repeat (4) @(posedge aclk);
        measure(per, lo, co, nl);
        check(((lo - lo0 - t) % dv + dv) % dv == 0, "launch tap");
        check(((co - co0 - u) % dv + dv) % dv == 0, "capture tap");
      end
    end
    $display("test taps done");
    d = $urandom;
    axi_wr(ocp_pkg::PHYCFG_OFS, d, 4'hf, r);
    f = d;
    check(tx_delay_line_setting === d[6:0] && rx_delay_line_setting === d[22:16], "delays");
    e = $urandom;
    axi_wr(ocp_pkg::PHYCFG_OFS, e, 4'h4, r);
    axi_rd(ocp_pkg::PHYCFG_OFS, d, r);
    check(d === {9'h0, e[22:16], 9'h0, f[6:0]} && r === ocp_pkg::RESP_OKAY, "byte lane");
    check(rx_delay_line_setting === e[22:16] && tx_delay_line_setting === f[6:0], "rx delay");
    axi_rd(8'h10, d, r);
    check(r === ocp_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    axi_wr(8'h10, 32'hffff_ffff, 4'hf, r);
    check(r === ocp_pkg::RESP_SLVERR, "unmapped write");
    axi_wr(ocp_pkg::STAT_OFS, 32'h0, 4'hf, r);
    check(r === ocp_pkg::RESP_SLVERR, "status write");
    $display("test registers done");
    axi_wr(ocp_pkg::CTRL_OFS, 32'h1d, 4'hf, r);
    mem_drive <= 1'h1;
    mem_toggle <= 1'h1;
    @(posedge aclk);
    mem_toggle <= 1'h0;
    repeat (5) @(posedge aclk);
    axi_rd(ocp_pkg::STAT_OFS, d, r);
    check(d[5:0] === 6'h3a, "strobe high");
    mem_drive <= 1'h0;
    repeat (5) @(posedge aclk);
    axi_rd(ocp_pkg::STAT_OFS, d, r);
    check(d[5:0] === 6'h2a, "strobe released");
    $display("test strobe done");
    stop_test();
  end
endmodule
`default_nettype wire
